// ===== rtl/aacc_config_cal.sv
// Configuration registers and digital calibration of the auxiliary converter.
// Assumes APB master on mclk; raw results arrive from logic on the same clock.
//
// Behaviour
// - Rate field bits 7:6 selects output rate.
// - Reference field bits 5:3 selects reference pair.
// - Gain field bits 2:0 gives two-power gain.
// - Positive selector bits 7:4, reset input 0.
// - Negative selector bits 3:0, reset input 1.
// - Offset word from two bytes, resets zero.
// - Offset word left-aligned to 24-bit result.
// - Subtract offset before full-scale scaling.
// - Full-scale word unsigned, resets to 4000h.
// - Gain factor equals full-scale word over 4000h.
// - Multiply offset-corrected result by gain factor.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module aacc_config_cal (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire aacc_pkg::aacc_sample_t rawSample,
    output aacc_pkg::aacc_sample_t      calSample,
    output aacc_pkg::aacc_setting_t     auxSetting,
    output aacc_pkg::aacc_mux_t         auxMux
);

    // -------------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------------
    logic [7:0]  cfgReg;
    logic [7:0]  muxReg;
    logic [7:0]  ofsLoReg;
    logic [7:0]  ofsHiReg;
    logic [7:0]  fsLoReg;
    logic [7:0]  fsHiReg;
    logic [31:0] rdData;

    logic [7:0]  next_cfgReg;
    logic [7:0]  next_muxReg;
    logic [7:0]  next_ofsLoReg;
    logic [7:0]  next_ofsHiReg;
    logic [7:0]  next_fsLoReg;
    logic [7:0]  next_fsHiReg;
    logic [31:0] next_rdData;

    logic [5:0]  wordIdx;
    logic        addrHit;
    logic        setupPhase;
    logic        writeAccess;
    logic        laneZero;

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    // Registers sit on word boundaries; the index is the word address.
    assign wordIdx     = paddr[7:2];
    assign setupPhase  = psel && !penable;
    assign writeAccess = psel && penable && pwrite && ce;
    assign laneZero    = pstrb[0];

    always_comb begin
        addrHit = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            addrHit = 1'b0;
        end else if (wordIdx == aacc_pkg::CFG_IDX[5:0]) begin
            addrHit = 1'b1;
        end else if (wordIdx == aacc_pkg::MUX_IDX[5:0]) begin
            addrHit = 1'b1;
        end else if (wordIdx == aacc_pkg::OFS_LO_IDX[5:0]) begin
            addrHit = 1'b1;
        end else if (wordIdx == aacc_pkg::OFS_HI_IDX[5:0]) begin
            addrHit = 1'b1;
        end else if (wordIdx == aacc_pkg::FS_LO_IDX[5:0]) begin
            addrHit = 1'b1;
        end else if (wordIdx == aacc_pkg::FS_HI_IDX[5:0]) begin
            addrHit = 1'b1;
        end
    end

    // Zero wait states; a frozen block stretches the access phase instead.
    assign pready  = ce;
    assign pslverr = psel && penable && !addrHit;
    assign prdata  = rdData;

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    always_comb begin
        next_cfgReg   = cfgReg;
        next_muxReg   = muxReg;
        next_ofsLoReg = ofsLoReg;
        next_ofsHiReg = ofsHiReg;
        next_fsLoReg  = fsLoReg;
        next_fsHiReg  = fsHiReg;
        if (writeAccess && laneZero && paddr[1:0] == 2'h0) begin
            if (wordIdx == aacc_pkg::CFG_IDX[5:0]) begin
                next_cfgReg = pwdata[7:0];
            end else if (wordIdx == aacc_pkg::MUX_IDX[5:0]) begin
                next_muxReg = pwdata[7:0];
            end else if (wordIdx == aacc_pkg::OFS_LO_IDX[5:0]) begin
                next_ofsLoReg = pwdata[7:0];
            end else if (wordIdx == aacc_pkg::OFS_HI_IDX[5:0]) begin
                next_ofsHiReg = pwdata[7:0];
            end else if (wordIdx == aacc_pkg::FS_LO_IDX[5:0]) begin
                next_fsLoReg = pwdata[7:0];
            end else if (wordIdx == aacc_pkg::FS_HI_IDX[5:0]) begin
                next_fsHiReg = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfgReg   <= aacc_pkg::CFG_RESET;
            muxReg   <= aacc_pkg::MUX_RESET;
            ofsLoReg <= aacc_pkg::OFS_LO_RESET;
            ofsHiReg <= aacc_pkg::OFS_HI_RESET;
            fsLoReg  <= aacc_pkg::FS_LO_RESET;
            fsHiReg  <= aacc_pkg::FS_HI_RESET;
        end else if (ce) begin
            cfgReg   <= next_cfgReg;
            muxReg   <= next_muxReg;
            ofsLoReg <= next_ofsLoReg;
            ofsHiReg <= next_ofsHiReg;
            fsLoReg  <= next_fsLoReg;
            fsHiReg  <= next_fsHiReg;
        end
    end

    // -------------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------------
    // Read data is fetched during setup so it stands through the access.
    always_comb begin
        next_rdData = rdData;
        if (setupPhase) begin
            next_rdData = 32'h0000_0000;
            if (paddr[1:0] != 2'h0) begin
                next_rdData = 32'h0000_0000;
            end else if (wordIdx == aacc_pkg::CFG_IDX[5:0]) begin
                next_rdData[7:0] = cfgReg;
            end else if (wordIdx == aacc_pkg::MUX_IDX[5:0]) begin
                next_rdData[7:0] = muxReg;
            end else if (wordIdx == aacc_pkg::OFS_LO_IDX[5:0]) begin
                next_rdData[7:0] = ofsLoReg;
            end else if (wordIdx == aacc_pkg::OFS_HI_IDX[5:0]) begin
                next_rdData[7:0] = ofsHiReg;
            end else if (wordIdx == aacc_pkg::FS_LO_IDX[5:0]) begin
                next_rdData[7:0] = fsLoReg;
            end else if (wordIdx == aacc_pkg::FS_HI_IDX[5:0]) begin
                next_rdData[7:0] = fsHiReg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdData <= 32'h0000_0000;
        end else if (ce) begin
            rdData <= next_rdData;
        end
    end

    // -------------------------------------------------------------------------
    // Setting outputs
    // -------------------------------------------------------------------------
    aacc_pkg::aacc_setting_t settingReg;
    aacc_pkg::aacc_setting_t next_settingReg;
    aacc_pkg::aacc_mux_t     muxOut;
    aacc_pkg::aacc_mux_t     next_muxOut;

    always_comb begin
        next_settingReg.auxRateSel =
            aacc_pkg::aacc_rate_t'(next_cfgReg[aacc_pkg::RATE_LSB +: 2]);
        next_settingReg.auxRefSel =
            aacc_pkg::aacc_ref_t'(next_cfgReg[aacc_pkg::REF_LSB +: 3]);
        next_settingReg.auxGainSel = next_cfgReg[aacc_pkg::GAIN_LSB +: 3];
        next_settingReg.auxGainFactor =
            8'h01 << next_cfgReg[aacc_pkg::GAIN_LSB +: 3];
        // Codes above the supply pair select no reference at all.
        next_settingReg.refReserved =
            next_cfgReg[aacc_pkg::REF_LSB +: 3] > aacc_pkg::REF_SUPPLY;
        next_muxOut.auxPosInputSel =
            aacc_pkg::aacc_input_t'(next_muxReg[aacc_pkg::POS_LSB +: 4]);
        next_muxOut.auxNegInputSel =
            aacc_pkg::aacc_input_t'(next_muxReg[aacc_pkg::NEG_LSB +: 4]);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // Reset outputs are decoded from the register reset values so both agree.
            settingReg.auxRateSel    <=
                aacc_pkg::aacc_rate_t'(aacc_pkg::CFG_RESET[aacc_pkg::RATE_LSB +: 2]);
            settingReg.auxRefSel     <=
                aacc_pkg::aacc_ref_t'(aacc_pkg::CFG_RESET[aacc_pkg::REF_LSB +: 3]);
            settingReg.auxGainSel    <= aacc_pkg::CFG_RESET[aacc_pkg::GAIN_LSB +: 3];
            settingReg.auxGainFactor <=
                8'h01 << aacc_pkg::CFG_RESET[aacc_pkg::GAIN_LSB +: 3];
            settingReg.refReserved   <=
                aacc_pkg::CFG_RESET[aacc_pkg::REF_LSB +: 3] > aacc_pkg::REF_SUPPLY;
            muxOut.auxPosInputSel    <=
                aacc_pkg::aacc_input_t'(aacc_pkg::MUX_RESET[aacc_pkg::POS_LSB +: 4]);
            muxOut.auxNegInputSel    <=
                aacc_pkg::aacc_input_t'(aacc_pkg::MUX_RESET[aacc_pkg::NEG_LSB +: 4]);
        end else if (ce) begin
            settingReg <= next_settingReg;
            muxOut     <= next_muxOut;
        end
    end

    assign auxSetting = settingReg;
    assign auxMux     = muxOut;

    // -------------------------------------------------------------------------
    // Calibration: offset stage
    // -------------------------------------------------------------------------
    logic signed [15:0] auxOffsetWord;
    logic        [15:0] auxFullscaleWord;
    logic signed [23:0] offsetAligned;
    logic signed [24:0] diffWide;

    aacc_pkg::aacc_sample_t ofsStage;
    aacc_pkg::aacc_sample_t next_ofsStage;

    // Each byte acts on its own write, so a mixed word is in use between the two.
    assign auxOffsetWord    = {ofsHiReg, ofsLoReg};
    assign auxFullscaleWord = {fsHiReg, fsLoReg};
    assign offsetAligned    = {auxOffsetWord, 8'h00};

    always_comb begin
        diffWide = {rawSample.code[23], rawSample.code}
                 - {offsetAligned[23], offsetAligned};
        // A sample offered while ce is low is not taken.
        next_ofsStage.valid = rawSample.valid;
        next_ofsStage.code  = ofsStage.code;
        if (rawSample.valid) begin
            if (diffWide[24] != diffWide[23]) begin
                next_ofsStage.code = diffWide[24] ? 24'sh800000
                                                  : 24'sh7FFFFF;
            end else begin
                next_ofsStage.code = diffWide[23:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ofsStage <= '{1'b0, 24'sh000000};
        end else if (ce) begin
            ofsStage <= next_ofsStage;
        end
    end

    // -------------------------------------------------------------------------
    // Calibration: full-scale stage
    // -------------------------------------------------------------------------
    logic signed [40:0] product;
    logic               prodFits;

    aacc_pkg::aacc_sample_t outStage;
    aacc_pkg::aacc_sample_t next_outStage;

    always_comb begin
        // Unsigned word extended by a zero so the product stays signed.
        product = ofsStage.code * $signed({1'b0, auxFullscaleWord});
        prodFits = (product[40:37] == {4{product[37]}});
        next_outStage.valid = ofsStage.valid;
        next_outStage.code  = outStage.code;
        if (ofsStage.valid) begin
            if (!prodFits) begin
                next_outStage.code = product[40] ? 24'sh800000
                                                 : 24'sh7FFFFF;
            end else begin
                next_outStage.code =
                    product[aacc_pkg::FS_UNITY_SHIFT +: 24];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            outStage <= '{1'b0, 24'sh000000};
        end else if (ce) begin
            outStage <= next_outStage;
        end
    end

    assign calSample = outStage;

endmodule : aacc_config_cal

// ===== rtl/aacc_pkg.sv
// Package of the auxiliary converter configuration and calibration block.
// Holds register indices, field positions, reset values, modes and carrier types.
// Assumes an APB slave with 32-bit data; each byte register sits in the low lane.
package aacc_pkg;

    // -------------------------------------------------------------------------
    // Register indices and reset values
    // -------------------------------------------------------------------------
    localparam logic [7:0] CFG_IDX      = 8'h15;
    localparam logic [7:0] MUX_IDX      = 8'h16;
    localparam logic [7:0] OFS_LO_IDX   = 8'h17;
    localparam logic [7:0] OFS_HI_IDX   = 8'h18;
    localparam logic [7:0] FS_LO_IDX    = 8'h19;
    localparam logic [7:0] FS_HI_IDX    = 8'h1A;

    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] MUX_RESET    = 8'h01;
    localparam logic [7:0] OFS_LO_RESET = 8'h00;
    localparam logic [7:0] OFS_HI_RESET = 8'h00;
    localparam logic [7:0] FS_LO_RESET  = 8'h00;
    localparam logic [7:0] FS_HI_RESET  = 8'h40;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int RATE_LSB = 6;
    localparam int REF_LSB  = 3;
    localparam int GAIN_LSB = 0;
    localparam int POS_LSB  = 4;
    localparam int NEG_LSB  = 0;

    // Full-scale word of unity gain is 2 to this power.
    localparam int FS_UNITY_SHIFT = 14;

    // -------------------------------------------------------------------------
    // Modes
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_10SPS  = 2'h0,
        RATE_100SPS = 2'h1,
        RATE_400SPS = 2'h2,
        RATE_800SPS = 2'h3
    } aacc_rate_t;

    typedef enum logic [2:0] {
        REF_INTERNAL = 3'h0,
        REF_AIN01    = 3'h1,
        REF_AIN23    = 3'h2,
        REF_AIN45    = 3'h3,
        REF_SUPPLY   = 3'h4,
        REF_RSVD5    = 3'h5,
        REF_RSVD6    = 3'h6,
        REF_RSVD7    = 3'h7
    } aacc_ref_t;

    typedef enum logic [3:0] {
        IN_AIN0 = 4'h0, IN_AIN1 = 4'h1, IN_AIN2 = 4'h2, IN_AIN3 = 4'h3,
        IN_AIN4 = 4'h4, IN_AIN5 = 4'h5, IN_AIN6 = 4'h6, IN_AIN7 = 4'h7,
        IN_AIN8 = 4'h8, IN_AIN9 = 4'h9, IN_COMMON = 4'hA, IN_TEMP = 4'hB,
        IN_AVDD = 4'hC, IN_DVDD = 4'hD, IN_TEST = 4'hE, IN_OPEN = 4'hF
    } aacc_input_t;

    // -------------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------------
    typedef struct packed {
        aacc_rate_t  auxRateSel;
        aacc_ref_t   auxRefSel;
        logic [2:0]  auxGainSel;
        logic [7:0]  auxGainFactor;
        logic        refReserved;
    } aacc_setting_t;

    typedef struct packed {
        aacc_input_t auxPosInputSel;
        aacc_input_t auxNegInputSel;
    } aacc_mux_t;

    typedef struct packed {
        logic               valid;
        logic signed [23:0] code;
    } aacc_sample_t;

endpackage : aacc_pkg

// ===== sim/aacc_config_cal_properties.sv
// Port checker of the auxiliary converter configuration and calibration block.
// Assumes byte address = register index times four and a single clock domain.
`timescale 1ns/1ps

module aacc_config_cal_properties (
    input wire logic                    mclk,
    input wire logic                    reset_n,
    input wire logic                    ce,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire aacc_pkg::aacc_sample_t  rawSample,
    input wire aacc_pkg::aacc_sample_t  calSample,
    input wire aacc_pkg::aacc_setting_t auxSetting,
    input wire aacc_pkg::aacc_mux_t     auxMux
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence sWrite(logic [7:0] a);
        psel && penable && pwrite && ce && pstrb[0] && paddr == a;
    endsequence

    sequence sRaw;
        rawSample.valid && ce ##1 ce;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_RATE_WRITE: assert property (
        sWrite(8'h54) |=> auxSetting.auxRateSel == $past(pwdata[7:6]))
        else $error("Rate field differs from write.");
    AST_REF_WRITE: assert property (
        sWrite(8'h54) |=> auxSetting.auxRefSel == $past(pwdata[5:3]))
        else $error("Reference field differs from write.");
    AST_GAIN_WRITE: assert property (
        sWrite(8'h54) |=> auxSetting.auxGainSel == $past(pwdata[2:0])
        && auxSetting.auxGainFactor == 8'h01 << $past(pwdata[2:0]))
        else $error("Gain field or factor differs from write.");
    AST_REF_RESERVED: assert property (
        auxSetting.refReserved == (auxSetting.auxRefSel > 3'h4))
        else $error("Reserved reference flag wrong.");
    AST_POS_WRITE: assert property (
        sWrite(8'h58) |=> auxMux.auxPosInputSel == $past(pwdata[7:4]))
        else $error("Positive selector differs from write.");
    AST_NEG_WRITE: assert property (
        sWrite(8'h58) |=> auxMux.auxNegInputSel == $past(pwdata[3:0]))
        else $error("Negative selector differs from write.");
    AST_MUX_RESET: assert property (
        $rose(reset_n) |-> auxMux == 8'h01 && auxSetting.auxGainFactor == 8'h01)
        else $error("Selector reset value wrong.");
    AST_CFG_READ: assert property (
        psel && penable && !pwrite && ce && paddr == 8'h54 |-> prdata == {24'h0,
        auxSetting.auxRateSel, auxSetting.auxRefSel, auxSetting.auxGainSel})
        else $error("Configuration read differs from fields.");
    AST_CAL_LATENCY: assert property (
        sRaw |=> calSample.valid)
        else $error("Calibrated result missing two cycles after raw.");
endmodule : aacc_config_cal_properties

bind aacc_config_cal aacc_config_cal_properties i_props (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rawSample(rawSample), .calSample(calSample),
    .auxSetting(auxSetting), .auxMux(auxMux));

// ===== sim/aux_adc_config_calibration_bench.sv
// Self-checking bench of the auxiliary converter configuration and calibration block.
// Assumes the APB byte address of each register is its index times four.
`timescale 1ns/1ps

module aux_adc_config_calibration_bench;
    logic                    mclk = 1'h0;
    logic                    reset_n = 1'h0;
    logic                    ce = 1'h1;
    logic                    psel = 1'h0;
    logic                    penable = 1'h0;
    logic                    pwrite = 1'h0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0;
    logic [3:0]              pstrb = 4'hF;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    aacc_pkg::aacc_sample_t  rawSample = '0;
    aacc_pkg::aacc_sample_t  calSample;
    aacc_pkg::aacc_setting_t auxSetting;
    aacc_pkg::aacc_mux_t     auxMux;
    int                      fails = 0;
    int                      tests_run = 0;
    logic [31:0]             rd;
    logic                    err;
    logic [7:0]  rstVal [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h40};
    logic [15:0] ofs [8] = '{16'h0, 16'h100, 16'h100, 16'h0, 16'h7FFF, 16'hFF00, 16'h0, 16'h0};
    logic [15:0] fsw [8] = '{16'h4000, 16'h4000, 16'h8000, 16'h8000, 16'h4000, 16'h4000,
                             16'h2000, 16'hC000};
    logic [23:0] raw [8] = '{24'h123456, 24'h20000, 24'h20000, 24'h7FFFFF, 24'h800000,
                             24'h0, 24'hFFFFFD, 24'h100};
    logic [23:0] expd [8] = '{24'h123456, 24'h10000, 24'h20000, 24'h7FFFFF, 24'h800000,
                              24'h10000, 24'hFFFFFE, 24'h300};

    aacc_config_cal i_dut (
        .mclk(mclk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rawSample(rawSample), .calSample(calSample),
        .auxSetting(auxSetting), .auxMux(auxMux));

    initial begin
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [7:0] ra(input int i);
        return 8'((aacc_pkg::CFG_IDX + 8'(i)) << 2);
    endfunction : ra

    task automatic results;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // One APB transfer; st cycles of clock enable low stretch its access phase.
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, input int st);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'h1;
        if (st > 0) begin
            ce <= 1'h0;
            repeat (st) @(posedge mclk);
            ce <= 1'h1;
        end
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            fails++;
            $display("MISMATCH pready expected 1 seen 0");
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask : apb

    task automatic conv(input logic [23:0] r, input logic [23:0] e);
        int n;
        n = 0;
        rawSample <= '{1'h1, r};
        @(posedge mclk);
        rawSample <= '{1'h0, r};
        do begin
            @(posedge mclk);
            n++;
        end while (calSample.valid !== 1'h1 && n < 10);
        if (calSample.valid !== 1'h1) begin
            fails++;
            $display("MISMATCH calibrated valid expected 1 seen 0");
            results();
        end
        check("result latency", 32'h2, n);
        check("calibrated code", {8'h0, e}, {8'h0, calSample.code});
    endtask : conv

    task automatic chkReset;
        for (int i = 0; i < 6; i++) begin
            apb(ra(i), 1'h0, 8'h00, 0);
            check("reset value", {24'h0, rstVal[i]}, rd);
            check("mapped error", 32'h0, {31'h0, err});
        end
        check("reset select", 32'h1, {24'h0, auxMux});
    endtask : chkReset

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin : main
        logic [7:0] v;
        repeat (20) @(posedge mclk);
        reset_n <= 1'h1;
        @(posedge mclk);
        chkReset();
        for (int i = 0; i < 8; i++) begin
            v = {i[1:0], i[2:0], i[2:0]};
            apb(ra(0), 1'h1, v, i % 3);
            check("setting", {15'h0, v, 8'(1 << i), i > 4}, {15'h0, auxSetting});
            apb(ra(0), 1'h0, 8'h00, (i + 1) % 3);
            check("config read", {24'h0, v}, rd);
        end
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], 4'(15 - i)};
            apb(ra(1), 1'h1, v, 0);
            check("select", {24'h0, v}, {24'h0, auxMux});
            apb(ra(1), 1'h0, 8'h00, 0);
            check("select read", {24'h0, v}, rd);
        end
        apb(8'h50, 1'h1, 8'h00, 0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(8'h55, 1'h1, 8'h00, 0);
        check("unaligned error", 32'h1, {31'h0, err});
        apb(8'h55, 1'h0, 8'h00, 0);
        check("unaligned read", 32'h0, rd);
        apb(ra(0), 1'h0, 8'h00, 0);
        check("config kept", 32'hFF, rd);
        pstrb <= 4'hE;
        apb(ra(1), 1'h1, 8'h77, 0);
        pstrb <= 4'hF;
        apb(ra(1), 1'h0, 8'h00, 0);
        check("masked write", 32'hF0, rd);
        for (int i = 0; i < 8; i++) begin
            apb(ra(2), 1'h1, ofs[i][7:0], 0);
            apb(ra(3), 1'h1, ofs[i][15:8], 0);
            apb(ra(4), 1'h1, fsw[i][7:0], 0);
            apb(ra(5), 1'h1, fsw[i][15:8], 0);
            conv(raw[i], expd[i]);
        end
        reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        @(posedge mclk);
        chkReset();
        results();
    end
endmodule : aux_adc_config_calibration_bench
